//--- bce_enum.sv
// module: bounds check enumeration, bounds registers and range fault
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps

// Behaviour
// - leaf 07h ebx bit 14 reports support
// - leaf 0dh sub 0 gives component vector
// - eax bit 3 reports register component
// - eax bit 4 reports config/status component
// - both bits one with extension present
// - subleaf 3 gives register size, offset
// - subleaf 4 gives config size, offset
// - four bounds registers, lower and upper
// - user and supervisor enables independent
// - out-of-bounds reference raises range fault
// - absent or disabled: instructions do nothing
// - reset clears all four bounds registers
module bce_enum #(
   parameter bit PRESENT = 1'b1  // extension implemented
) (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  reset_i,
   // register port
   input  wire logic [7:0]            addr_i,
   input  wire logic [31:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [31:0]           rdata_o,
   // check request from the pipeline
   input  wire bce_pkg::bce_chk_s     chk_i,
   // check answer
   output logic                       fault_o,
   output logic                       done_o,
   // interrupt
   output logic                       irq_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   bce_pkg::bce_state_s state_reg;  // registered state
   bce_pkg::bce_state_s state_next; // next state

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // identify answer for one register of four (0 eax .. 3 edx)
   function automatic logic [31:0] ident(input logic [31:0] leaf, input logic [31:0] sub,
                                         input logic [1:0] reg_sel);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (leaf == bce_pkg::LEAF_FEATURES && sub == bce_pkg::SUB_ZERO) begin
         if (reg_sel == 2'h1) begin
            v[bce_pkg::FEAT_BIT] = PRESENT;
         end
      end else if (leaf == bce_pkg::LEAF_XSTATE && sub == bce_pkg::SUB_ZERO) begin
         if (reg_sel == 2'h0) begin
            v = bce_pkg::BASE_COMP_MASK;
            v[bce_pkg::COMP_REGS_BIT] = PRESENT;
            v[bce_pkg::COMP_CSR_BIT] = PRESENT;
         end
         // edx holds the high half of the vector, all zero here
      end else if (leaf == bce_pkg::LEAF_XSTATE && sub == bce_pkg::SUB_REG_STATE && PRESENT) begin
         if (reg_sel == 2'h0) begin
            v = bce_pkg::REGS_SIZE;
         end else if (reg_sel == 2'h1) begin
            v = bce_pkg::REGS_OFFSET;
         end
      end else if (leaf == bce_pkg::LEAF_XSTATE && sub == bce_pkg::SUB_CFG_STATE && PRESENT) begin
         if (reg_sel == 2'h0) begin
            v = bce_pkg::CSR_SIZE;
         end else if (reg_sel == 2'h1) begin
            v = bce_pkg::CSR_OFFSET;
         end
      end
      return v;
   endfunction

   // is the extension usable at this privilege level
   function automatic logic active(input bce_pkg::bce_state_s s, input logic user);
      logic en;
      en = user ? s.cfgu[bce_pkg::CFG_EN_BIT] : s.cfgs[bce_pkg::CFG_EN_BIT];
      // software must have both components on
      return PRESENT && en && s.xfe[bce_pkg::COMP_REGS_BIT] && s.xfe[bce_pkg::COMP_CSR_BIT];
   endfunction

   // ----------------------------------------------------------------
   // bounds word view for reads, one per 32-bit slice
   // ----------------------------------------------------------------
   logic [31:0] bnd_word [0:15]; // word view of bounds_regs

   genvar gi;
   generate
      for (gi = 0; gi < bce_pkg::NUM_BND; gi++) begin : g_bnd
         // four words per register: lb low, lb high, ub low, ub high
         assign bnd_word[gi*4+0] = state_reg.bnd[gi].lb[31:0];
         assign bnd_word[gi*4+1] = state_reg.bnd[gi].lb[63:32];
         assign bnd_word[gi*4+2] = state_reg.bnd[gi].ub[31:0];
         assign bnd_word[gi*4+3] = state_reg.bnd[gi].ub[63:32];
      end
   endgenerate

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [63:0] lb;     // selected lower bound
      logic [63:0] ub;     // selected upper bound, true form
      logic        outb;   // reference out of bounds
      logic [1:0]  ev;     // events this cycle
      logic [3:0]  widx;   // bounds word index
      lb = 64'h0;
      ub = 64'h0;
      outb = 1'b0;
      ev = 2'h0;
      widx = addr_i[5:2];
      state_next = state_reg;
      state_next.fault = 1'b0;
      state_next.done = 1'b0;
      state_next.rdata = 32'h0000_0000;

      // check path: a no-op when absent or not enabled
      if (chk_i.valid) begin
         state_next.done = 1'b1;
         if (active(state_reg, chk_i.user)) begin
            lb = state_reg.bnd[chk_i.idx].lb;
            ub = ~state_reg.bnd[chk_i.idx].ub;
            outb = chk_i.upper ? (chk_i.addr > ub) : (chk_i.addr < lb);
            if (outb) begin
               state_next.fault = 1'b1;
               state_next.status[1:0] = bce_pkg::EC_VIOL;
               ev[bce_pkg::EV_FAULT] = 1'b1;
            end
         end else begin
            ev[bce_pkg::EV_NOP] = 1'b1;
         end
      end

      // register writes
      if (wr_i) begin
         case (addr_i)
            bce_pkg::OFF_ID_LEAF: begin
               state_next.leaf = wdata_i;
            end
            bce_pkg::OFF_ID_SUB: begin
               state_next.sub = wdata_i;
            end
            bce_pkg::OFF_XFE: begin
               state_next.xfe = wdata_i;
            end
            bce_pkg::OFF_CFGU: begin
               state_next.cfgu = wdata_i;
            end
            bce_pkg::OFF_CFGS: begin
               state_next.cfgs = wdata_i;
            end
            bce_pkg::OFF_STATUS: begin
               if (!ev[bce_pkg::EV_FAULT]) begin
                  state_next.status = wdata_i; // fault capture wins
               end
            end
            bce_pkg::OFF_IRQ_STAT: begin
               state_next.irq_stat = state_reg.irq_stat & ~wdata_i[1:0];
            end
            bce_pkg::OFF_IRQ_MASK: begin
               state_next.irq_mask = wdata_i[1:0];
            end
            default: begin
               // bounds words, writable only when the extension exists
               if (PRESENT && addr_i >= bce_pkg::OFF_BND_BASE && addr_i <= bce_pkg::OFF_BND_LAST) begin
                  case (widx[1:0])
                     2'h0: state_next.bnd[widx[3:2]].lb[31:0] = wdata_i;
                     2'h1: state_next.bnd[widx[3:2]].lb[63:32] = wdata_i;
                     2'h2: state_next.bnd[widx[3:2]].ub[31:0] = wdata_i;
                     default: state_next.bnd[widx[3:2]].ub[63:32] = wdata_i;
                  endcase
               end
            end
         endcase
      end

      // sticky events: set wins over clear
      state_next.irq_stat = state_next.irq_stat | ev;
      state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

      // register reads, data one cycle later
      if (rd_i) begin
         case (addr_i)
            bce_pkg::OFF_ID_LEAF:  state_next.rdata = state_reg.leaf;
            bce_pkg::OFF_ID_SUB:   state_next.rdata = state_reg.sub;
            bce_pkg::OFF_ID_EAX:   state_next.rdata = ident(state_reg.leaf, state_reg.sub, 2'h0);
            bce_pkg::OFF_ID_EBX:   state_next.rdata = ident(state_reg.leaf, state_reg.sub, 2'h1);
            bce_pkg::OFF_ID_ECX:   state_next.rdata = ident(state_reg.leaf, state_reg.sub, 2'h2);
            bce_pkg::OFF_ID_EDX:   state_next.rdata = ident(state_reg.leaf, state_reg.sub, 2'h3);
            bce_pkg::OFF_XFE:      state_next.rdata = state_reg.xfe;
            bce_pkg::OFF_CFGU:     state_next.rdata = state_reg.cfgu;
            bce_pkg::OFF_CFGS:     state_next.rdata = state_reg.cfgs;
            bce_pkg::OFF_STATUS:   state_next.rdata = state_reg.status;
            bce_pkg::OFF_IRQ_STAT: state_next.rdata = {30'h0, state_reg.irq_stat};
            bce_pkg::OFF_IRQ_MASK: state_next.rdata = {30'h0, state_reg.irq_mask};
            default: begin
               if (addr_i >= bce_pkg::OFF_BND_BASE && addr_i <= bce_pkg::OFF_BND_LAST) begin
                  state_next.rdata = bnd_word[widx];
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flip-flops
   assign rdata_o = state_reg.rdata;
   assign fault_o = state_reg.fault;
   assign done_o  = state_reg.done;
   assign irq_o   = state_reg.irq;

endmodule // bce_enum

//--- bce_pkg.sv
// package: constants and carriers of the bounds check enumeration block
package bce_pkg;

   // ----------------------------------------------------------------
   // identify_instruction leaves and fields
   // ----------------------------------------------------------------
   localparam logic [31:0] LEAF_FEATURES   = 32'h0000_0007; // extended feature leaf
   localparam logic [31:0] LEAF_XSTATE     = 32'h0000_000d; // saved state leaf
   localparam logic [31:0] SUB_ZERO        = 32'h0000_0000; // subleaf 0
   localparam logic [31:0] SUB_REG_STATE   = 32'h0000_0003; // subleaf of bound_register_state
   localparam logic [31:0] SUB_CFG_STATE   = 32'h0000_0004; // subleaf of bound_config_status_state
   localparam int          FEAT_BIT        = 14;            // ebx support bit, leaf 07h
   localparam int          COMP_REGS_BIT   = 3;             // bound_register_state component bit
   localparam int          COMP_CSR_BIT    = 4;             // bound_config_status_state component bit
   localparam logic [31:0] BASE_COMP_MASK  = 32'h0000_0007; // other components reported (x87/sse/avx)
   // component sizes and offsets: implementation values
   localparam logic [31:0] REGS_SIZE       = 32'h0000_0040; // four registers of 16 bytes
   localparam logic [31:0] REGS_OFFSET     = 32'h0000_03c0; // save-area offset, arbitrary
   localparam logic [31:0] CSR_SIZE        = 32'h0000_0040; // config and status, padded
   localparam logic [31:0] CSR_OFFSET      = 32'h0000_0400; // save-area offset, arbitrary

   // ----------------------------------------------------------------
   // register offsets on the software port
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_ID_LEAF  = 8'h00; // leaf selector
   localparam logic [7:0] OFF_ID_SUB   = 8'h04; // subleaf selector
   localparam logic [7:0] OFF_ID_EAX   = 8'h08; // answer eax
   localparam logic [7:0] OFF_ID_EBX   = 8'h0c; // answer ebx
   localparam logic [7:0] OFF_ID_ECX   = 8'h10; // answer ecx
   localparam logic [7:0] OFF_ID_EDX   = 8'h14; // answer edx
   localparam logic [7:0] OFF_XFE      = 8'h18; // extended_feature_enable low word
   localparam logic [7:0] OFF_CFGU     = 8'h1c; // user_bound_config low word
   localparam logic [7:0] OFF_CFGS     = 8'h20; // supervisor config low word
   localparam logic [7:0] OFF_STATUS   = 8'h24; // bound_status_word low word
   localparam logic [7:0] OFF_IRQ_STAT = 8'h28; // sticky events, write one to clear
   localparam logic [7:0] OFF_IRQ_MASK = 8'h2c; // event mask
   localparam logic [7:0] OFF_BND_BASE = 8'h40; // bounds_regs words, 4 per register
   localparam logic [7:0] OFF_BND_LAST = 8'h7c; // last bounds word

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int          CFG_EN_BIT  = 0;             // enable bit of both configs
   localparam logic [1:0]  EC_NONE     = 2'h0;          // no exception
   localparam logic [1:0]  EC_VIOL     = 2'h1;          // bounds violation
   localparam logic [31:0] RST_WORD    = 32'h0000_0000; // reset of every register
   localparam int          NUM_BND     = 4;             // number of bounds registers
   localparam int          EV_FAULT    = 0;             // event bit: bound_range_fault
   localparam int          EV_NOP      = 1;             // event bit: check done as no-op

   // check request from the pipeline
   typedef struct packed {
      logic        valid;   // one-cycle check request
      logic [1:0]  idx;     // bounds register index
      logic        upper;   // 1: upper bound check, 0: lower
      logic        user;    // privilege_level is 3
      logic [63:0] addr;    // effective address
   } bce_chk_s;

   // one bounds register
   typedef struct packed {
      logic [63:0] ub;      // upper bound, one's complement
      logic [63:0] lb;      // lower bound
   } bce_bnd_s;

   // all state of the block
   typedef struct packed {
      bce_bnd_s [3:0] bnd;        // bounds_regs
      logic [31:0]    leaf;       // identify leaf
      logic [31:0]    sub;        // identify subleaf
      logic [31:0]    xfe;        // extended_feature_enable
      logic [31:0]    cfgu;       // user_bound_config
      logic [31:0]    cfgs;       // supervisor config
      logic [31:0]    status;     // bound_status_word
      logic [1:0]     irq_stat;   // sticky events
      logic [1:0]     irq_mask;   // event mask
      logic [31:0]    rdata;      // read data
      logic           fault;      // fault pulse
      logic           done;       // check answer pulse
      logic           irq;        // interrupt level
   } bce_state_s;

endpackage

//--- bce_enum_monitor.sv
// checker: port-level assertions of the bounds check enumeration block
`timescale 1ns/100ps
module bce_enum_monitor (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   // register port
   input  wire logic [7:0]        addr_i,
   input  wire logic [31:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic [31:0]       rdata_o,
   // check port
   input  wire bce_pkg::bce_chk_s chk_i,
   input  wire logic              fault_o,
   input  wire logic              done_o,
   input  wire logic              irq_o
);
   // ----------------------------------------------------------------
   // shadow of selectors and enables
   // ----------------------------------------------------------------
   logic [31:0] leaf_reg;  // leaf selector copy
   logic [31:0] sub_reg;   // subleaf selector copy
   logic [1:0]  xfe_reg;   // feature enable bits 4:3
   logic        cfgu_reg;  // user enable copy
   logic        cfgs_reg;  // supervisor enable copy
   logic        act;       // checks are live for this request
   assign act = (xfe_reg == 2'b11) && (chk_i.user ? cfgu_reg : cfgs_reg);
   // follow software writes, cleared on reset
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         leaf_reg <= '0;
         sub_reg  <= '0;
         xfe_reg  <= '0;
         cfgu_reg <= 1'b0;
         cfgs_reg <= 1'b0;
      end else if (wr_i) begin
         if (addr_i == bce_pkg::OFF_ID_LEAF) leaf_reg <= wdata_i;
         if (addr_i == bce_pkg::OFF_ID_SUB) sub_reg <= wdata_i;
         if (addr_i == bce_pkg::OFF_XFE) xfe_reg <= wdata_i[4:3];
         if (addr_i == bce_pkg::OFF_CFGU) cfgu_reg <= wdata_i[0];
         if (addr_i == bce_pkg::OFF_CFGS) cfgs_reg <= wdata_i[0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   // read of one answer word under a given leaf and subleaf
   sequence s_id(logic [31:0] lf, logic [31:0] sb, logic [7:0] off);
      rd_i && addr_i == off && leaf_reg == lf && sub_reg == sb;
   endsequence
   property p_done; chk_i.valid |=> done_o; endproperty
   property p_fault_done; fault_o |-> done_o && $past(chk_i.valid); endproperty
   property p_inactive; chk_i.valid && !act |=> !fault_o; endproperty
   property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
   property p_comp;
      s_id(bce_pkg::LEAF_XSTATE, bce_pkg::SUB_ZERO, bce_pkg::OFF_ID_EAX) |=>
         rdata_o == (bce_pkg::BASE_COMP_MASK | 32'h18);
   endproperty
   property p_comp_hi;
      s_id(bce_pkg::LEAF_XSTATE, bce_pkg::SUB_ZERO, bce_pkg::OFF_ID_EDX) |=> rdata_o == 32'h0;
   endproperty
   property p_feat;
      s_id(bce_pkg::LEAF_FEATURES, bce_pkg::SUB_ZERO, bce_pkg::OFF_ID_EBX) |=> rdata_o[14];
   endproperty
   property p_regs_sz;
      s_id(bce_pkg::LEAF_XSTATE, bce_pkg::SUB_REG_STATE, bce_pkg::OFF_ID_EAX) |=> rdata_o == bce_pkg::REGS_SIZE;
   endproperty
   property p_csr_sz;
      s_id(bce_pkg::LEAF_XSTATE, bce_pkg::SUB_CFG_STATE, bce_pkg::OFF_ID_EAX) |=> rdata_o == bce_pkg::CSR_SIZE;
   endproperty
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_done: assert property (p_done) else $error("no answer after check");
   a_fault_done: assert property (p_fault_done) else $error("fault without check");
   a_inactive: assert property (p_inactive) else $error("fault while disabled");
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   a_comp: assert property (p_comp) else $error("component vector wrong");
   a_comp_hi: assert property (p_comp_hi) else $error("upper vector wrong");
   a_feat: assert property (p_feat) else $error("support bit clear");
   a_regs_sz: assert property (p_regs_sz) else $error("register state size wrong");
   a_csr_sz: assert property (p_csr_sz) else $error("config state size wrong");
endmodule // bce_enum_monitor

bind bce_enum bce_enum_monitor mon (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .chk_i,
   .fault_o, .done_o, .irq_o);

//--- bce_enum_tb_top.sv
// testbench: self-checking bench of the bounds check enumeration block
`timescale 1ns/100ps
module bce_enum_tb_top;
   logic              clk_i = 1'b0;       // core clock
   logic              reset_i = 1'b1;     // synchronous reset
   logic [7:0]        addr_i = 8'h00;     // register address
   logic [31:0]       wdata_i = 32'h0;    // write data
   logic              wr_i = 1'b0;        // write strobe
   logic              rd_i = 1'b0;        // read strobe
   bce_pkg::bce_chk_s chk_i = '0;         // check request
   logic [31:0]       rdata_o;            // read data
   logic              fault_o;            // range fault pulse
   logic              done_o;             // check answer pulse
   logic              irq_o;              // interrupt level
   int                fails = 0;          // mismatches
   int                comparisons = 0;    // compares made
   logic [31:0]       seed = 32'h3da0;    // xorshift state
   logic [63:0]       lb [4];             // expected lower bounds
   logic [63:0]       hi [4];             // expected upper bounds, plain form
   logic [31:0]       d;                  // read result
   logic [63:0]       a;                  // check address
   logic [5:0]        r;                  // random selectors
   bce_enum dut (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .chk_i, .fault_o, .done_o, .irq_o);
   initial forever #10 clk_i = ~clk_i;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // word w of the bounds window: lb lo, lb hi, ub lo, ub hi per register
   function automatic logic [31:0] bnd_word(int w);
      logic [127:0] q;
      q = {~hi[w / 4], lb[w / 4]};
      return q[32 * (w % 4) +: 32];
   endfunction
   function automatic logic want_fault(logic act, logic up, logic [63:0] ad, logic [1:0] ix);
      return act && (up ? ad > hi[ix] : ad < lb[ix]);
   endfunction
   task automatic cmp_word(logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(logic got, logic exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic wr(logic [7:0] ad, logic [31:0] dt);
      @(posedge clk_i);
      addr_i <= ad;
      wdata_i <= dt;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(logic [7:0] ad, output logic [31:0] dt);
      @(posedge clk_i);
      addr_i <= ad;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 dt = rdata_o;
   endtask
   task automatic check(logic [1:0] ix, logic up, logic us, logic [63:0] ad, logic act);
      @(posedge clk_i);
      chk_i <= {1'b1, ix, up, us, ad};
      @(posedge clk_i);
      chk_i.valid <= 1'b0;
      #1;
      cmp_bit(done_o, 1'b1);
      cmp_bit(fault_o, want_fault(act, up, ad, ix));
   endtask
   task automatic ident(logic [31:0] lf, logic [31:0] sb, logic [7:0] off, logic [31:0] msk, logic [31:0] ex);
      logic [31:0] v;
      wr(bce_pkg::OFF_ID_LEAF, lf);
      wr(bce_pkg::OFF_ID_SUB, sb);
      rd(off, v);
      cmp_word(v & msk, ex);
   endtask
   // whole enumeration, run with different software state
   task automatic enum_all();
      ident(bce_pkg::LEAF_FEATURES, 32'h0, bce_pkg::OFF_ID_EBX, 32'h4000, 32'h4000);
      ident(bce_pkg::LEAF_XSTATE, 32'h0, bce_pkg::OFF_ID_EAX, 32'h18, 32'h18);
      ident(bce_pkg::LEAF_XSTATE, 32'h0, bce_pkg::OFF_ID_EDX, '1, 32'h0);
      ident(bce_pkg::LEAF_XSTATE, 32'h3, bce_pkg::OFF_ID_EAX, '1, bce_pkg::REGS_SIZE);
      ident(bce_pkg::LEAF_XSTATE, 32'h3, bce_pkg::OFF_ID_EBX, '1, bce_pkg::REGS_OFFSET);
      ident(bce_pkg::LEAF_XSTATE, 32'h4, bce_pkg::OFF_ID_EAX, '1, bce_pkg::CSR_SIZE);
      ident(bce_pkg::LEAF_XSTATE, 32'h4, bce_pkg::OFF_ID_EBX, '1, bce_pkg::CSR_OFFSET);
   endtask
   task automatic final_report();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      final_report();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int w = 0; w < 16; w++) begin
         rd(bce_pkg::OFF_BND_BASE + 8'(4 * w), d);
         cmp_word(d, 32'h0);
      end
      rd(8'h80, d);
      cmp_word(d, 32'h0);
      enum_all();
      for (int i = 0; i < 4; i++) begin
         lb[i] = {1'b0, 31'(rnd()), rnd()};
         hi[i] = lb[i] + 64'(rnd() & 32'hffff);
      end
      for (int w = 0; w < 16; w++) wr(bce_pkg::OFF_BND_BASE + 8'(4 * w), bnd_word(w));
      for (int w = 0; w < 16; w++) begin
         rd(bce_pkg::OFF_BND_BASE + 8'(4 * w), d);
         cmp_word(d, bnd_word(w));
      end
      // feature disabled: checks do nothing
      for (int i = 0; i < 8; i++) check(2'(i), i[2], i[0], lb[i % 4] - 64'h1, 1'b0);
      rd(bce_pkg::OFF_IRQ_STAT, d);
      cmp_bit(d[bce_pkg::EV_NOP], 1'b1);
      wr(bce_pkg::OFF_XFE, 32'h18);
      wr(bce_pkg::OFF_IRQ_STAT, 32'h3);
      wr(bce_pkg::OFF_IRQ_MASK, 32'h1);
      for (int m = 0; m < 2; m++) begin
         wr(bce_pkg::OFF_CFGU, 32'(m == 0));
         wr(bce_pkg::OFF_CFGS, 32'(m == 1));
         for (int n = 0; n < 40; n++) begin
            r = 6'(rnd());
            case (r[5:4])
               2'h0: a = r[2] ? hi[r[1:0]] : lb[r[1:0]];
               2'h1: a = r[2] ? hi[r[1:0]] + 64'h1 : lb[r[1:0]] - 64'h1;
               default: a = (r[2] ? hi[r[1:0]] : lb[r[1:0]]) + 64'(rnd() & 32'h1ffff) - 64'h10000;
            endcase
            check(r[1:0], r[2], r[3], a, r[3] ^ m[0]);
         end
      end
      // fault with unmasked interrupt, then clear, then masked
      check(2'h0, 1'b0, 1'b0, lb[0] - 64'h1, 1'b1);
      rd(bce_pkg::OFF_STATUS, d);
      cmp_word(32'(d[1:0]), 32'(bce_pkg::EC_VIOL));
      cmp_bit(irq_o, 1'b1);
      wr(bce_pkg::OFF_IRQ_STAT, 32'h3);
      rd(bce_pkg::OFF_IRQ_STAT, d);
      cmp_bit(irq_o, 1'b0);
      wr(bce_pkg::OFF_IRQ_MASK, 32'h0);
      check(2'h1, 1'b1, 1'b0, hi[1] + 64'h1, 1'b1);
      rd(bce_pkg::OFF_IRQ_STAT, d);
      cmp_bit(d[bce_pkg::EV_FAULT], 1'b1);
      cmp_bit(irq_o, 1'b0);
      enum_all();
      final_report();
   end
endmodule // bce_enum_tb_top
